// [sdtp_defs.svh]
`ifndef SDTP_DEFS_SVH
`define SDTP_DEFS_SVH
// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define SDTP_ADDR_CFG3   12'h0f8
`define SDTP_ADDR_CFG4   12'h0fc
`define SDTP_ADDR_STAT   12'h100
// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define SDTP_CFG3_RST    32'h0000_0000
`define SDTP_CFG4_RST    32'h0000_0000
`define SDTP_CFG3_WMASK  32'hf000_0000
`define SDTP_CFG4_WMASK  32'hff0c_ffff
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SDTP_F_PREACT    31:28
`define SDTP_F_ACTPRE    27:24
`define SDTP_F_RELOAD_A  19:18
`define SDTP_F_REGMOD    15
`define SDTP_F_CASLAT    14:12
`define SDTP_F_BSTLEN    10:8
`define SDTP_F_ACTRW     7:4
`define SDTP_F_RELOAD_C  3:0
`define SDTP_F_RELOAD_B  31:28
// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define SDTP_IVL_ZERO    5'h10
`define SDTP_NUM_BANKS   4
`endif

// [sdtp_pkg.sv]
`default_nettype none
package sdtp_pkg;
	// Requested memory operation from the sequencing core
	typedef enum logic [2:0] {
		OP_NOP,
		OP_ACT,
		OP_READ,
		OP_WRITE,
		OP_PRE,
		OP_MODE
	} sdtp_op_t;

	typedef struct packed {
		logic        valid;
		sdtp_op_t    op;
		logic [1:0]  bank;
		logic [12:0] addr;
		logic [31:0] wdata;
		logic [3:0]  wpar;
	} sdtp_req_t;

	// SDRAM command pins, all strobes active low
	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [1:0]  ba;
		logic [12:0] addr;
	} sdtp_cmd_t;

	// Write data lane: oe_n low while driving
	typedef struct packed {
		logic        oe_n;
		logic [31:0] data;
		logic [3:0]  par;
	} sdtp_wr_t;
endpackage : sdtp_pkg
`default_nettype wire

// [sdtp_bank_timer.sv]
`default_nettype none
`include "sdtp_defs.svh"
module sdtp_bank_timer
	import sdtp_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_reset,
	input  wire logic       i_act,
	input  wire logic       i_access,
	input  wire logic       i_pre,
	input  wire logic [9:0] i_reload,
	input  wire logic [4:0] i_act_rw,
	input  wire logic [4:0] i_act_pre,
	input  wire logic [4:0] i_pre_act,
	output logic            o_open,
	output logic            o_rw_ok,
	output logic            o_pre_ok,
	output logic            o_act_ok,
	output logic            o_expire
);
	logic [9:0] page_cnt, next_page_cnt;
	logic [4:0] rw_cnt, next_rw_cnt;
	logic [4:0] ap_cnt, next_ap_cnt;
	logic [4:0] pa_cnt, next_pa_cnt;
	logic       open, next_open;

	// ------------------------------------------------------------
	// Next state: page timer and spacing counters
	// ------------------------------------------------------------
	always_comb begin
		next_open = i_act ? 1'b1 : (i_pre ? 1'b0 : open);
		next_page_cnt = page_cnt;
		if (i_access) begin
			next_page_cnt = i_reload;
		end else if (open && page_cnt != 10'h000) begin
			next_page_cnt = page_cnt - 10'h001;
		end
		next_rw_cnt = i_act ? i_act_rw : (rw_cnt != 5'h00 ? rw_cnt - 5'h01 : rw_cnt);
		next_ap_cnt = i_act ? i_act_pre : (ap_cnt != 5'h00 ? ap_cnt - 5'h01 : ap_cnt);
		next_pa_cnt = i_pre ? i_pre_act : (pa_cnt != 5'h00 ? pa_cnt - 5'h01 : pa_cnt);
	end

	// Counter of N means the command is allowed N cycles after the load
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			open     <= 1'b0;
			page_cnt <= 10'h000;
			rw_cnt   <= 5'h00;
			ap_cnt   <= 5'h00;
			pa_cnt   <= 5'h00;
		end else begin
			open     <= next_open;
			page_cnt <= next_page_cnt;
			rw_cnt   <= next_rw_cnt;
			ap_cnt   <= next_ap_cnt;
			pa_cnt   <= next_pa_cnt;
		end
	end

	assign o_open   = open;
	assign o_rw_ok  = rw_cnt <= 5'h01;
	assign o_pre_ok = !open || ap_cnt <= 5'h01;
	assign o_act_ok = pa_cnt <= 5'h01;
	assign o_expire = open && page_cnt == 10'h000;

	// ------------------------------------------------------------
	// Checks: cycles since the last activate and precharge
	// ------------------------------------------------------------
	logic [5:0] since_act;
	logic [5:0] since_pre;
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			since_act <= 6'h3f;
			since_pre <= 6'h3f;
		end else begin
			since_act <= i_act ? 6'h01 : (since_act != 6'h3f ? since_act + 6'h01 : since_act);
			since_pre <= i_pre ? 6'h01 : (since_pre != 6'h3f ? since_pre + 6'h01 : since_pre);
		end
	end

	property p_rw_spacing;
		@(posedge i_mclk) disable iff (i_reset) (o_open && o_rw_ok) |-> since_act >= {1'b0, i_act_rw};
	endproperty
	a_rw_spacing: assert property (p_rw_spacing) else $error("read/write allowed too soon after activate");

	property p_pre_spacing;
		@(posedge i_mclk) disable iff (i_reset) (o_open && o_pre_ok) |-> since_act >= {1'b0, i_act_pre};
	endproperty
	a_pre_spacing: assert property (p_pre_spacing) else $error("precharge allowed too soon");

	property p_act_spacing;
		@(posedge i_mclk) disable iff (i_reset) o_act_ok |-> since_pre >= {1'b0, i_pre_act};
	endproperty
	a_act_spacing: assert property (p_act_spacing) else $error("activate allowed too soon");

	property p_reload_holds;
		@(posedge i_mclk) disable iff (i_reset) (i_access && !i_pre && i_reload != 10'h000) |=> !o_expire;
	endproperty
	a_reload_holds: assert property (p_reload_holds) else $error("page expired right after access");

	property p_expiry;
		@(posedge i_mclk) disable iff (i_reset)
			(open && page_cnt == 10'h002 && !i_access && !i_pre) ##1 (!i_access && !i_pre) |=> o_expire;
	endproperty
	a_expiry: assert property (p_expiry) else $error("page timer failed to expire");
endmodule : sdtp_bank_timer
`default_nettype wire

// [sdtp_sdram_timing.sv]
// Functional notes
// - Reload value = cfg4[19:18] (top), cfg3[31:28], cfg4[3:0] (bottom).
// - Every access to an open page reloads its page timer with full value.
// - An expired page timer closes that bank with a precharge command.
// - Registered-module bit set: write data and parity one cycle after command.
// - Mode register write uses cfg4[14:12] and cfg4[10:8] as mode data; cfg4[11] is driven as zero.
// - Mode register opcode field is always driven as zeros.
// - Read or write waits activate-to-rdwr cycles after activate; code 0 is 16.
// - Precharge-to-activate and activate-to-precharge counted in clocks; 0 is 16.
`default_nettype none
`include "sdtp_defs.svh"
module sdtp_sdram_timing
	import sdtp_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire sdtp_req_t   i_req,
	output logic             o_req_ready,
	output sdtp_cmd_t        o_cmd,
	output sdtp_wr_t         o_wr
);
	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0] cfg3, next_cfg3;
	logic [31:0] cfg4, next_cfg4;
	logic [31:0] prdata, next_prdata;
	logic        pslverr, next_pslverr;
	logic [3:0]  open, rw_ok, pre_ok, act_ok, expire;
	logic        setup, wr_acc;

	assign setup  = i_psel && !i_penable;
	assign wr_acc = i_psel && i_penable && i_pwrite;

	// Read data is prepared in the setup cycle so the slave never waits
	always_comb begin
		next_cfg3    = cfg3;
		next_cfg4    = cfg4;
		next_prdata  = prdata;
		next_pslverr = pslverr;
		if (wr_acc && i_paddr == `SDTP_ADDR_CFG3) begin
			next_cfg3 = i_pwdata & `SDTP_CFG3_WMASK;
		end
		if (wr_acc && i_paddr == `SDTP_ADDR_CFG4) begin
			next_cfg4 = i_pwdata & `SDTP_CFG4_WMASK;
		end
		if (setup) begin
			next_pslverr = 1'b0;
			unique case (i_paddr)
				`SDTP_ADDR_CFG3: next_prdata = cfg3;
				`SDTP_ADDR_CFG4: next_prdata = cfg4;
				`SDTP_ADDR_STAT: next_prdata = {24'h00_0000, expire, open};
				default: begin
					next_prdata  = 32'h0000_0000;
					next_pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			cfg3    <= `SDTP_CFG3_RST;
			cfg4    <= `SDTP_CFG4_RST;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			cfg3    <= next_cfg3;
			cfg4    <= next_cfg4;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	assign o_prdata  = prdata;
	assign o_pready  = 1'b1;
	assign o_pslverr = pslverr && i_psel && i_penable;

	// ------------------------------------------------------------
	// Decoded timing values
	// ------------------------------------------------------------
	function automatic logic [4:0] ivl_decode(input logic [3:0] code);
		ivl_decode = (code == 4'h0) ? `SDTP_IVL_ZERO : {1'b0, code};
	endfunction : ivl_decode

	logic [9:0] reload;
	logic [4:0] act_rw, act_pre, pre_act;
	logic       regmod;

	assign reload  = {cfg4[`SDTP_F_RELOAD_A], cfg3[`SDTP_F_RELOAD_B], cfg4[`SDTP_F_RELOAD_C]};
	assign act_rw  = ivl_decode(cfg4[`SDTP_F_ACTRW]);
	assign act_pre = ivl_decode(cfg4[`SDTP_F_ACTPRE]);
	assign pre_act = ivl_decode(cfg4[`SDTP_F_PREACT]);
	assign regmod  = cfg4[`SDTP_F_REGMOD];

	// ------------------------------------------------------------
	// Per-bank timers
	// ------------------------------------------------------------
	logic [3:0] bank_act, bank_access, bank_pre;

	generate
		for (genvar g = 0; g < `SDTP_NUM_BANKS; g++) begin : g_bank
			sdtp_bank_timer u_timer (
				.i_mclk    (i_mclk),
				.i_reset   (i_reset),
				.i_act     (bank_act[g]),
				.i_access  (bank_access[g]),
				.i_pre     (bank_pre[g]),
				.i_reload  (reload),
				.i_act_rw  (act_rw),
				.i_act_pre (act_pre),
				.i_pre_act (pre_act),
				.o_open    (open[g]),
				.o_rw_ok   (rw_ok[g]),
				.o_pre_ok  (pre_ok[g]),
				.o_act_ok  (act_ok[g]),
				.o_expire  (expire[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Command arbitration
	// ------------------------------------------------------------
	logic       close_hit;
	logic [1:0] close_bank;
	logic       legal;
	logic       issue;
	sdtp_cmd_t  cmd, next_cmd;
	logic [3:0] req_sel;

	// Page closing beats new requests so an expired page never lingers
	always_comb begin
		close_hit  = 1'b0;
		close_bank = 2'b00;
		for (int i = `SDTP_NUM_BANKS - 1; i >= 0; i--) begin
			if (expire[i] && pre_ok[i]) begin
				close_hit  = 1'b1;
				close_bank = 2'(i);
			end
		end
		req_sel = 4'h1 << i_req.bank;
		unique case (i_req.op)
			OP_NOP:   legal = 1'b1;
			OP_ACT:   legal = !open[i_req.bank] && act_ok[i_req.bank];
			OP_READ:  legal = open[i_req.bank] && rw_ok[i_req.bank];
			OP_WRITE: legal = open[i_req.bank] && rw_ok[i_req.bank];
			OP_PRE:   legal = pre_ok[i_req.bank];
			OP_MODE:  legal = open == 4'h0 && act_ok == 4'hf;
			default:  legal = 1'b0;
		endcase
		issue       = i_req.valid && legal && !close_hit;
		bank_act    = (issue && i_req.op == OP_ACT) ? req_sel : 4'h0;
		bank_access = (issue && (i_req.op == OP_ACT || i_req.op == OP_READ || i_req.op == OP_WRITE))
		              ? req_sel : 4'h0;
		bank_pre    = close_hit ? (4'h1 << close_bank) : ((issue && i_req.op == OP_PRE) ? req_sel : 4'h0);
	end

	assign o_req_ready = legal && !close_hit;

	// Command pins; column commands never auto-precharge, the page timer owns closing
	always_comb begin
		next_cmd = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'b00, addr: 13'h0000};
		if (close_hit) begin
			next_cmd = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b1, we_n: 1'b0, ba: close_bank, addr: 13'h0000};
		end else if (issue) begin
			next_cmd.ba = i_req.bank;
			unique case (i_req.op)
				OP_NOP: begin
					next_cmd.ba = 2'b00;
				end
				OP_ACT: begin
					next_cmd = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b1, we_n: 1'b1, ba: i_req.bank, addr: i_req.addr};
				end
				OP_READ, OP_WRITE: begin
					next_cmd.cs_n  = 1'b0;
					next_cmd.cas_n = 1'b0;
					next_cmd.we_n  = i_req.op != OP_WRITE;
					next_cmd.addr  = i_req.addr & 13'h1bff;
				end
				OP_PRE: begin
					next_cmd.cs_n  = 1'b0;
					next_cmd.ras_n = 1'b0;
					next_cmd.we_n  = 1'b0;
				end
				OP_MODE: begin
					next_cmd      = '{cs_n: 1'b0, ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0, ba: 2'b00, addr: 13'h0000};
					next_cmd.addr = {6'h00, cfg4[`SDTP_F_CASLAT], 1'b0, cfg4[`SDTP_F_BSTLEN]};
				end
				default: begin
					next_cmd.ba = 2'b00;
				end
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			cmd <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: 2'b00, addr: 13'h0000};
		end else begin
			cmd <= next_cmd;
		end
	end

	assign o_cmd = cmd;

	// ------------------------------------------------------------
	// Write data lane
	// ------------------------------------------------------------
	sdtp_wr_t wr_s1, next_wr_s1;
	sdtp_wr_t wr_out, next_wr_out;

	// Registered modules latch the command a cycle early, so data trails by one
	always_comb begin
		next_wr_s1 = '{oe_n: 1'b1, data: 32'h0000_0000, par: 4'h0};
		if (issue && i_req.op == OP_WRITE) begin
			next_wr_s1 = '{oe_n: 1'b0, data: i_req.wdata, par: i_req.wpar};
		end
		next_wr_out = regmod ? wr_s1 : next_wr_s1;
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			wr_s1  <= '{oe_n: 1'b1, data: 32'h0000_0000, par: 4'h0};
			wr_out <= '{oe_n: 1'b1, data: 32'h0000_0000, par: 4'h0};
		end else begin
			wr_s1  <= next_wr_s1;
			wr_out <= next_wr_out;
		end
	end

	assign o_wr = wr_out;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic cmd_is_write, cmd_is_mode, cmd_is_pre;
	assign cmd_is_write = !o_cmd.cs_n && o_cmd.ras_n && !o_cmd.cas_n && !o_cmd.we_n;
	assign cmd_is_mode  = !o_cmd.cs_n && !o_cmd.ras_n && !o_cmd.cas_n && !o_cmd.we_n;
	assign cmd_is_pre   = !o_cmd.cs_n && !o_cmd.ras_n && o_cmd.cas_n && !o_cmd.we_n;

	property p_wr_registered;
		@(posedge i_mclk) disable iff (i_reset)
			(issue && i_req.op == OP_WRITE && regmod) ##1 regmod |->
			cmd_is_write && o_wr.oe_n ##1 (!o_wr.oe_n && o_wr.data == $past(i_req.wdata, 2));
	endproperty
	a_wr_registered: assert property (p_wr_registered) else $error("registered write data not one cycle late");

	property p_wr_normal;
		@(posedge i_mclk) disable iff (i_reset)
			(issue && i_req.op == OP_WRITE && !regmod) |=> (cmd_is_write && !o_wr.oe_n && o_wr.par == $past(i_req.wpar));
	endproperty
	a_wr_normal: assert property (p_wr_normal) else $error("unbuffered write data not aligned with command");

	property p_mode_word;
		@(posedge i_mclk) disable iff (i_reset)
			cmd_is_mode |-> (o_cmd.addr[12:7] == 6'h00 && o_cmd.addr[3] == 1'b0
			&& o_cmd.addr[6:4] == $past(cfg4[`SDTP_F_CASLAT]) && o_cmd.addr[2:0] == $past(cfg4[`SDTP_F_BSTLEN]));
	endproperty
	a_mode_word: assert property (p_mode_word) else $error("mode register word malformed");

	property p_close;
		@(posedge i_mclk) disable iff (i_reset)
			(|(expire & pre_ok)) |=> (cmd_is_pre && open[o_cmd.ba] == 1'b0);
	endproperty
	a_close: assert property (p_close) else $error("expired page not precharged");

	property p_reserved_zero;
		@(posedge i_mclk) disable iff (i_reset)
			(setup && i_paddr == `SDTP_ADDR_CFG4) |=> o_prdata[17:16] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

	property p_reload_value;
		@(posedge i_mclk) disable iff (i_reset)
			reload[9:8] == cfg4[19:18] && reload[7:4] == cfg3[31:28] && reload[3:0] == cfg4[3:0];
	endproperty
	a_reload_value: assert property (p_reload_value) else $error("reload value assembled wrongly");
endmodule : sdtp_sdram_timing
`default_nettype wire

// [sdtp_sdram_model.sv]
`default_nettype none
module sdtp_sdram_model
	import sdtp_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire sdtp_cmd_t  i_cmd,
	input  wire sdtp_wr_t   i_wr,
	output var logic [12:0] o_mode,
	output var logic [1:0]  o_wlag,
	output var logic [35:0] o_wbeat,
	output var logic [7:0]  o_wcnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] strobes;
	logic [1:0] age;
	logic [1:0] cur;
	assign strobes = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
	// Cycles since the last write command; saturates so a stray beat shows as lag 3
	assign cur = (strobes == 4'b0100) ? 2'd0 : ((age == 2'd3) ? age : age + 2'd1);
	initial begin
		age = 2'd3;
		o_mode = '0;
		o_wlag = 2'd3;
		o_wbeat = '0;
		o_wcnt = '0;
	end
	// Mode word latched on a mode command, beats captured while the lane drives
	always @(posedge i_mclk) begin
		age <= cur;
		if (strobes == 4'b0000) o_mode <= i_cmd.addr;
		if (!i_wr.oe_n) begin
			o_wlag <= cur;
			o_wbeat <= {i_wr.data, i_wr.par};
			o_wcnt <= o_wcnt + 8'd1;
		end
	end
endmodule : sdtp_sdram_model
`default_nettype wire

// [test_sdram_timing_page_config.sv]
`default_nettype none
`include "sdtp_defs.svh"
module test_sdram_timing_page_config
	import sdtp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk, i_reset, psel, penable, pwrite, pready, pslverr, req_ready, acc_d, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r, v, c4, wd;
	logic [12:0] mode, exp_mode;
	logic [1:0]  wlag, bk;
	logic [35:0] wbeat;
	logic [7:0]  wcnt;
	logic [3:0]  wp, x, y, z;
	logic [9:0]  rv;
	sdtp_req_t   req;
	sdtp_cmd_t   cmd;
	sdtp_wr_t    wr;
	sdtp_op_t    acc_op;
	int          error_cnt, n_checks, seed, k, t;
	int          codes[5] = '{2, 3, 15, 0, 7};
	logic [9:0]  rels[3] = '{10'h005, 10'h01a, 10'h105};

	sdtp_sdram_timing u_sdtp_sdram_timing (.i_mclk(i_mclk), .i_reset(i_reset), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_req(req), .o_req_ready(req_ready), .o_cmd(cmd), .o_wr(wr));
	sdtp_sdram_model u_sdtp_sdram_model (.i_mclk(i_mclk), .i_cmd(cmd), .i_wr(wr), .o_mode(mode),
		.o_wlag(wlag), .o_wbeat(wbeat), .o_wcnt(wcnt));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic int dec(input logic [3:0] c);
		return (c == 4'h0) ? 16 : int'(c);
	endfunction : dec
	function automatic logic [3:0] enc(input sdtp_op_t op);
		case (op)
			OP_ACT: return 4'b0011;
			OP_READ: return 4'b0101;
			OP_WRITE: return 4'b0100;
			OP_PRE: return 4'b0010;
			OP_MODE: return 4'b0000;
			default: return 4'b1111;
		endcase
	endfunction : enc
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Called just after an edge; holds the request until pready is seen high
	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge i_mclk);
		penable <= 1'b1;
		@(posedge i_mclk);
		while (pready !== 1'b1) @(posedge i_mclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_mclk);
	endtask : apb
	task automatic cfg(input logic [31:0] c3, input logic [31:0] c4v);
		apb(1'b1, `SDTP_ADDR_CFG3, c3);
		apb(1'b1, `SDTP_ADDR_CFG4, c4v);
		c4 = c4v;
	endtask : cfg
	// Request stays up after acceptance so a follow-on request can be back to back
	task automatic issue(input sdtp_op_t op, input logic [1:0] b, output int n);
		wd = $random(seed);
		wp = 4'($random(seed));
		req.valid <= 1'b1;
		req.op <= op;
		req.bank <= b;
		req.addr <= 13'($random(seed));
		req.wdata <= wd;
		req.wpar <= wp;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 3000);
	endtask : issue
	task automatic idle(input int n);
		req.valid <= 1'b0;
		repeat (n) @(posedge i_mclk);
	endtask : idle
	task automatic final_report;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// Command must show in the cycle after each acceptance
	always @(posedge i_mclk) begin
		if (acc_d) begin
			chk("cmd", 32'(enc(acc_op)), 32'({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n}));
			if (acc_op == OP_MODE) chk("mode", 32'(cmd.addr), 32'(exp_mode));
			if (acc_op == OP_READ || acc_op == OP_WRITE) chk("no auto precharge", 32'(cmd.addr[10]), 32'h0);
		end
		acc_d <= !i_reset && req.valid && req_ready;
		acc_op <= req.op;
	end
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// Run is about a thousand cycles; this limit of 25000 cycles is over twenty times that
	initial begin
		#100000;
		error_cnt++;
		final_report;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 30;
		i_reset = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		req = '0;
		repeat (10) @(posedge i_mclk);
		i_reset <= 1'b0;
		@(posedge i_mclk);
		apb(1'b0, `SDTP_ADDR_CFG4, 32'h0);
		chk("cfg4 reset", r, 32'h0000_0000);
		apb(1'b1, 12'h104, 32'hffff_ffff);
		chk("unmapped err", 32'(e), 32'h1);
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			apb(1'b1, `SDTP_ADDR_CFG4, v);
			apb(1'b0, `SDTP_ADDR_CFG4, 32'h0);
			chk("cfg4 rw", r, v & 32'hff0c_ffff);
			apb(1'b1, `SDTP_ADDR_CFG3, v);
			apb(1'b0, `SDTP_ADDR_CFG3, 32'h0);
			chk("cfg3 rw", r, v & 32'hf000_0000);
		end
		// Mode words: bit 11 set on purpose, it must come out as zero
		for (int cl = 1; cl < 4; cl++) begin
			for (int bl = 2; bl < 4; bl++) begin
				cfg(32'h0, {8'h11, 8'h0, 1'b0, 3'(cl), 1'b1, 3'(bl), 8'h2f});
				exp_mode = {6'h0, c4[14:12], 1'b0, c4[10:8]};
				issue(OP_MODE, 2'd0, k);
				idle(3);
				chk("model mode", 32'(mode), 32'(exp_mode));
			end
		end
		// Spacing after activate and precharge, every figure measured in edges
		for (int i = 0; i < 5; i++) begin
			x = 4'(codes[i]);
			y = 4'($random(seed));
			z = 4'($random(seed));
			bk = 2'($random(seed));
			cfg(32'hf000_0000, {y, z, 8'h0c, 8'h00, x, 4'hf});
			idle(20);
			issue(OP_ACT, bk, k);
			issue(i[0] ? OP_WRITE : OP_READ, bk, k);
			chk("act to rdwr", 32'(k), 32'(dec(x)));
			t = dec(z) - dec(x);
			issue(OP_PRE, bk, k);
			chk("act to pre", 32'(k), 32'(t < 1 ? 1 : t));
			issue(OP_ACT, bk, k);
			chk("pre to act", 32'(k), 32'(dec(y)));
			issue(OP_PRE, bk, k);
			chk("act to pre b", 32'(k), 32'(dec(z)));
			// Spacing checks use the live settings, so let the last precharge age out first
			idle(20);
		end
		// Write lane timing for normal and registered modules
		for (int rg = 0; rg < 2; rg++) begin
			v = 32'(wcnt);
			cfg(32'hf000_0000, {16'h110c, 1'(rg), 7'h0, 8'h2f});
			idle(20);
			issue(OP_ACT, 2'd1, k);
			issue(OP_WRITE, 2'd1, k);
			idle(5);
			chk("write lag", 32'(wlag), 32'(rg));
			chk("write beat", wbeat[31:0], {wd[27:0], wp});
			chk("beat count", 32'(wcnt), v + 32'h1);
			issue(OP_PRE, 2'd1, k);
			idle(2);
		end
		// Page closes itself once the reload time runs out after the last hit
		for (int i = 0; i < 3; i++) begin
			rv = rels[i];
			bk = 2'($random(seed));
			cfg({rv[7:4], 28'h0}, {12'h110, rv[9:8], 2'b00, 8'h00, 4'h2, rv[3:0]});
			idle(20);
			issue(OP_ACT, bk, k);
			issue(OP_READ, bk, k);
			idle(2);
			issue(OP_READ, bk, k);
			req.valid <= 1'b0;
			k = 0;
			do begin
				@(posedge i_mclk);
				k++;
			end while (!({cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} == 4'b0010 && cmd.ba == bk) && k < 3000);
			chk("auto close", 32'(k), 32'(rv) + 32'h2);
			apb(1'b0, `SDTP_ADDR_STAT, 32'h0);
			chk("bank closed", 32'(r[bk]), 32'h0);
		end
		final_report;
	end
endmodule : test_sdram_timing_page_config
`default_nettype wire
